/* File: inc/cid_pkg.sv */
// constants, carrier types and byte helpers for the cascaded dma block
// assumes one 20 MHz clock and byte-wide io accesses held for one cycle
package cid_pkg;

   // ==========================================================
   // sizes and address segments
   localparam int NUM_CH = 8;
   localparam int CASCADE_CH = 4;
   localparam logic [3:0] BYTE_SEG = 4'h0;
   localparam logic [3:0] WORD_SEG = 4'hc;
   localparam logic [3:0] PAGE_SEG = 4'h8;

   // ==========================================================
   // register offsets inside a controller segment
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_MASK1 = 4'ha;
   localparam logic [3:0] OFS_MODE = 4'hb;
   localparam logic [3:0] OFS_PTR = 4'hc;
   localparam logic [3:0] OFS_MCLR = 4'hd;
   localparam logic [3:0] OFS_UNMASK = 4'he;
   localparam logic [3:0] OFS_MASKALL = 4'hf;

   // ==========================================================
   // field positions
   localparam int CMD_HOLD = 1;
   localparam int CMD_DIS = 2;
   localparam int MODE_AUTO = 2;
   localparam int MODE_DEC = 3;

   // ==========================================================
   // values after reset, and the terminal count value
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [3:0] MASK_RST = 4'hf;
   localparam logic [5:0] MODE_RST = 6'h00;
   localparam logic [7:0] PAGE_RST = 8'h00;
   localparam logic [15:0] CHAN_RST = 16'h0000;
   localparam logic [15:0] CNT_LAST = 16'h0000;

   // page register slot used by each channel
   localparam logic [3:0] PAGE_IDX [NUM_CH] = '{
      4'h7, 4'h3, 4'h1, 4'h2, 4'hf, 4'hb, 4'h9, 4'ha};

   // ==========================================================
   // carriers
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } cid_io_t;

   typedef struct packed {
      logic strobe;
      logic tc;
      logic wide;
      logic [1:0] kind;
   } cid_xfer_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_XFER} cid_state_t;

   // ==========================================================
   // byte lane helpers
   function automatic logic [15:0] put_byte(input logic [15:0] old,
                                            input logic hi,
                                            input logic [7:0] b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction : put_byte

   function automatic logic [7:0] get_byte(input logic [15:0] v,
                                           input logic hi);
      get_byte = hi ? v[15:8] : v[7:0];
   endfunction : get_byte

endpackage : cid_pkg

/* File: hw/cid_chan.sv */
// one dma channel: base and current address, base and current count
// assumes writes and steps never arrive in the same cycle
`timescale 1ns/1ps
module cid_chan (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic wr_addr_in,
   input wire logic wr_cnt_in,
   input wire logic hi_in,
   input wire logic [7:0] wdata_in,
   input wire logic step_in,
   input wire logic dec_in,
   input wire logic hold_in,
   input wire logic auto_in,
   output logic [15:0] addr_out,
   output logic [15:0] cnt_out,
   output logic tc_out
);

   logic [15:0] base_addr_q;
   logic [15:0] cur_addr_q;
   logic [15:0] base_cnt_q;
   logic [15:0] cur_cnt_q;

   // ==========================================================
   // address pair
   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         base_addr_q <= cid_pkg::CHAN_RST;
         cur_addr_q <= cid_pkg::CHAN_RST;
      end
      else if (wr_addr_in)
      begin
         base_addr_q <= cid_pkg::put_byte(base_addr_q, hi_in, wdata_in);
         cur_addr_q <= cid_pkg::put_byte(cur_addr_q, hi_in, wdata_in);
      end
      else if (step_in)
      begin
         if (tc_out && auto_in)
            cur_addr_q <= base_addr_q;
         else if (!hold_in)
            cur_addr_q <= dec_in ? cur_addr_q - 16'h0001
                                 : cur_addr_q + 16'h0001;
      end
   end

   // ==========================================================
   // count pair
   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         base_cnt_q <= cid_pkg::CHAN_RST;
         cur_cnt_q <= cid_pkg::CHAN_RST;
      end
      else if (wr_cnt_in)
      begin
         base_cnt_q <= cid_pkg::put_byte(base_cnt_q, hi_in, wdata_in);
         cur_cnt_q <= cid_pkg::put_byte(cur_cnt_q, hi_in, wdata_in);
      end
      else if (step_in)
      begin
         if (tc_out && auto_in)
            cur_cnt_q <= base_cnt_q;
         else
            cur_cnt_q <= cur_cnt_q - 16'h0001;
      end
   end

   // this transfer rolls the count over
   assign tc_out = (cur_cnt_q == cid_pkg::CNT_LAST);
   assign addr_out = cur_addr_q;
   assign cnt_out = cur_cnt_q;

endmodule : cid_chan

/* File: hw/cid_top.sv */
// two cascaded four-channel dma controllers with page registers
// assumes io strobes last one cycle and peripherals hold dreq until dack
//
// Overview of operation
// - byte and word controllers; word channel 0 cascades
// - requests 0-3 byte side, 5-7 word side
// - decode 000-00F, 0C0-0CF, pages 080-08F
// - every register access is one byte wide
// - access to a controller blocks its transfers
// - byte pointer toggles on address/count access
// - pointer cleared by reset, master clear; settable
// - transfer starts only on unmasked valid request
// - byte transfers drive address lines 0-15
// - word transfers drive lines 1-16, line 0 low
// - page bits drive address lines 16-23, 17-23 on word transfers
// - current address steps up or down per transfer
// - hold bit freezes channel 0 address
// - count decrements; terminal count on 0000 to FFFF
// - terminal count masks channel or autoinitializes
// - base address write-only, written with current
// - address reads current byte, writes base and current
// - count reads current byte, writes base and current
// - status read or clears drop terminal count flags
`timescale 1ns/1ps
module cid_top (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic cpu_reset_output_in,
   input wire cid_pkg::cid_io_t io_req_in,
   output logic [7:0] io_rdata_out,
   input wire logic [7:0] dreq_in,
   output logic [7:0] dack_out,
   output logic [23:0] sys_addr_out,
   output cid_pkg::cid_xfer_t xfer_out
);

   // ==========================================================
   // io decode
   logic any_acc;
   logic hit_b;
   logic hit_w;
   logic hit_p;
   logic sel;
   logic chan_reg;
   logic is_cnt;
   logic [3:0] ofs;
   logic [2:0] gch;
   logic [1:0] hit_ctl;
   logic [1:0] mclr;
   logic [1:0] stat_rd;

   always_comb
   begin
      any_acc = io_req_in.rd | io_req_in.wr;
      ofs = io_req_in.addr[3:0];
      hit_b = any_acc & (io_req_in.addr[7:4] == cid_pkg::BYTE_SEG);
      hit_w = any_acc & (io_req_in.addr[7:4] == cid_pkg::WORD_SEG);
      hit_p = any_acc & (io_req_in.addr[7:4] == cid_pkg::PAGE_SEG);
      hit_ctl = {hit_w, hit_b};
      sel = hit_w;
      chan_reg = (hit_b | hit_w) & ~ofs[3];
      is_cnt = ofs[0];
      gch = {sel, ofs[2:1]};
   end

   // ==========================================================
   // per controller state
   logic ptr_q [2];
   logic [7:0] cmd_q [2];
   logic [3:0] mask_q [2];
   logic [3:0] mask_d [2];
   logic [3:0] tc_q [2];
   logic [5:0] mode_q [cid_pkg::NUM_CH];
   logic [7:0] page_q [16];
   logic [7:0] tc_evt;
   logic [7:0] tc_mask;
   logic [7:0] mask_all;

   assign mask_all = {mask_q[1], mask_q[0]};

   for (genvar c = 0; c < 2; c++)
   begin : g_ctl
      always_comb
      begin
         mclr[c] = cpu_reset_output_in |
                   (io_req_in.wr & hit_ctl[c] & (ofs == cid_pkg::OFS_MCLR));
         stat_rd[c] = io_req_in.rd & hit_ctl[c] &
                      (ofs == cid_pkg::OFS_STATUS);
      end

      // byte pointer shared by all channel registers of the controller
      always_ff @(posedge ref_clk_in)
      begin
         if (!rstn_in || mclr[c])
            ptr_q[c] <= 1'b0;
         else if (hit_ctl[c] && chan_reg)
            ptr_q[c] <= ~ptr_q[c];
         else if (io_req_in.wr && hit_ctl[c] &&
                  ofs == cid_pkg::OFS_PTR)
            ptr_q[c] <= io_req_in.data[0];
      end

      always_ff @(posedge ref_clk_in)
      begin
         if (!rstn_in || mclr[c])
            cmd_q[c] <= cid_pkg::CMD_RST;
         else if (io_req_in.wr && hit_ctl[c] &&
                  ofs == cid_pkg::OFS_STATUS)
            cmd_q[c] <= io_req_in.data;
      end

      always_comb
      begin
         mask_d[c] = mask_q[c];
         if (io_req_in.wr && hit_ctl[c])
         begin
            case (ofs)
               cid_pkg::OFS_MASK1:
                  mask_d[c][io_req_in.data[1:0]] = io_req_in.data[2];
               cid_pkg::OFS_UNMASK:
                  mask_d[c] = 4'h0;
               cid_pkg::OFS_MASKALL:
                  mask_d[c] = io_req_in.data[3:0];
               default:
                  mask_d[c] = mask_q[c];
            endcase
         end
         mask_d[c] = mask_d[c] | tc_mask[c*4 +: 4];
      end

      always_ff @(posedge ref_clk_in)
      begin
         if (!rstn_in || mclr[c])
            mask_q[c] <= cid_pkg::MASK_RST;
         else
            mask_q[c] <= mask_d[c];
      end

      // a terminal count in the read cycle survives the clear
      always_ff @(posedge ref_clk_in)
      begin
         if (!rstn_in || mclr[c])
            tc_q[c] <= 4'h0;
         else
            tc_q[c] <= (stat_rd[c] ? 4'h0 : tc_q[c]) |
                       tc_evt[c*4 +: 4];
      end
   end

   // ==========================================================
   // mode and page registers
   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         for (int k = 0; k < cid_pkg::NUM_CH; k++)
            mode_q[k] <= cid_pkg::MODE_RST;
      end
      else if (io_req_in.wr && (hit_b || hit_w) &&
               ofs == cid_pkg::OFS_MODE)
         mode_q[{sel, io_req_in.data[1:0]}] <= io_req_in.data[7:2];
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         for (int k = 0; k < 16; k++)
            page_q[k] <= cid_pkg::PAGE_RST;
      end
      else if (io_req_in.wr && hit_p)
         page_q[ofs] <= io_req_in.data;
   end

   // ==========================================================
   // channels
   cid_pkg::cid_state_t st_q;
   logic [2:0] gnt_q;
   logic [7:0] elig;
   logic [7:0] step;
   logic [7:0] ch_wr;
   logic [7:0] hold;
   logic [7:0] ch_tc;
   logic [15:0] ch_addr [cid_pkg::NUM_CH];
   logic [15:0] ch_cnt [cid_pkg::NUM_CH];
   logic casc_open;

   // byte requests reach the bus only through the cascade channel
   assign casc_open = ~mask_q[1][0] & ~cmd_q[1][cid_pkg::CMD_DIS];

   for (genvar i = 0; i < cid_pkg::NUM_CH; i++)
   begin : g_ch
      assign ch_wr[i] = io_req_in.wr & chan_reg & (gch == 3'(i));
      assign hold[i] = ((i % 4) == 0) &
                       cmd_q[i/4][cid_pkg::CMD_HOLD];
      assign step[i] = (st_q == cid_pkg::ST_ADDR) & (gnt_q == 3'(i));
      assign tc_evt[i] = step[i] & ch_tc[i];
      assign tc_mask[i] = tc_evt[i] &
                          ~mode_q[i][cid_pkg::MODE_AUTO];
      // masked channels wait, so half-programmed ones stay idle
      assign elig[i] = (i != cid_pkg::CASCADE_CH) & dreq_in[i] &
                       ~mask_all[i] &
                       ~cmd_q[i/4][cid_pkg::CMD_DIS] &
                       ~hit_ctl[i/4] &
                       ((i >= 4) | casc_open);

      cid_chan u_chan (
         .ref_clk_in(ref_clk_in),
         .rstn_in(rstn_in),
         .wr_addr_in(ch_wr[i] & ~is_cnt),
         .wr_cnt_in(ch_wr[i] & is_cnt),
         .hi_in(ptr_q[i/4]),
         .wdata_in(io_req_in.data),
         .step_in(step[i]),
         .dec_in(mode_q[i][cid_pkg::MODE_DEC]),
         .hold_in(hold[i]),
         .auto_in(mode_q[i][cid_pkg::MODE_AUTO]),
         .addr_out(ch_addr[i]),
         .cnt_out(ch_cnt[i]),
         .tc_out(ch_tc[i])
      );
   end

   // ==========================================================
   // read data
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic [3:0] req_w;

   assign req_w = {dreq_in[7:5], |dreq_in[3:0]};

   always_comb
   begin
      rdata_d = 8'h00;
      if (hit_p)
         rdata_d = page_q[ofs];
      else if (chan_reg)
         rdata_d = cid_pkg::get_byte(is_cnt ? ch_cnt[gch] : ch_addr[gch],
                                     ptr_q[sel]);
      else if ((hit_b || hit_w) && ofs == cid_pkg::OFS_STATUS)
         rdata_d = sel ? {req_w, tc_q[1]} : {dreq_in[3:0], tc_q[0]};
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
         rdata_q <= 8'h00;
      else if (io_req_in.rd)
         rdata_q <= rdata_d;
   end

   // ==========================================================
   // transfer engine
   logic [2:0] nxt;
   logic [7:0] pg;
   logic [23:0] addr_d;
   logic [7:0] dack_q;
   logic [23:0] addr_q;
   cid_pkg::cid_xfer_t xfer_q;

   // lowest channel wins; byte channels sit behind the cascade
   function automatic logic [2:0] pick(input logic [7:0] v);
      pick = 3'h0;
      for (int k = 7; k >= 0; k--)
         if (v[k])
            pick = 3'(k);
   endfunction : pick

   always_comb
   begin
      nxt = pick(elig);
      pg = page_q[cid_pkg::PAGE_IDX[nxt]];
      if (nxt[2])
         addr_d = {pg[7:1], ch_addr[nxt], 1'b0};
      else
         addr_d = {pg, ch_addr[nxt]};
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in || cpu_reset_output_in)
      begin
         st_q <= cid_pkg::ST_IDLE;
         gnt_q <= 3'h0;
         dack_q <= 8'h00;
         addr_q <= 24'h000000;
         xfer_q <= '0;
      end
      else
      begin
         case (st_q)
            cid_pkg::ST_IDLE:
            begin
               xfer_q <= '0;
               if (|elig)
               begin
                  st_q <= cid_pkg::ST_ADDR;
                  gnt_q <= nxt;
                  dack_q <= 8'h01 << nxt;
                  addr_q <= addr_d;
               end
            end
            cid_pkg::ST_ADDR:
            begin
               xfer_q.strobe <= 1'b1;
               xfer_q.tc <= ch_tc[gnt_q];
               xfer_q.wide <= gnt_q[2];
               xfer_q.kind <= mode_q[gnt_q][1:0];
               st_q <= cid_pkg::ST_XFER;
            end
            cid_pkg::ST_XFER:
            begin
               xfer_q <= '0;
               dack_q <= 8'h00;
               st_q <= cid_pkg::ST_IDLE;
            end
            default:
               st_q <= cid_pkg::ST_IDLE;
         endcase
      end
   end

   assign io_rdata_out = rdata_q;
   assign dack_out = dack_q;
   assign sys_addr_out = addr_q;
   assign xfer_out = xfer_q;

   // ==========================================================
   // checks
   a_cascade_idle: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in) !dack_q[cid_pkg::CASCADE_CH])
      else $error("cascade channel acknowledged");

   a_ptr_toggle: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      (hit_b && chan_reg && !mclr[0]) |=> (ptr_q[0] != $past(ptr_q[0])))
      else $error("byte pointer did not toggle");

   a_ptr_clear: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      cpu_reset_output_in |=> (!ptr_q[0] && !ptr_q[1]))
      else $error("byte pointer not cleared");

   a_grant_req: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      $rose(dack_q[1]) |-> $past(dreq_in[1] && !mask_all[1]))
      else $error("grant without unmasked request");

   a_prog_block: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      (hit_b && st_q == cid_pkg::ST_IDLE) |=> (dack_q[3:0] == 4'h0))
      else $error("transfer began during programming");

   a_word_a0: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      (|dack_q[7:5]) |-> !sys_addr_out[0])
      else $error("address line 0 high on word transfer");

   a_page_bits: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      $rose(|dack_q) |->
      (sys_addr_out[23:17] == $past(pg[7:1])))
      else $error("page bits wrong on address lines");

   a_count_dec: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      (step[0] && !ch_tc[0]) |=> (ch_cnt[0] == $past(ch_cnt[0]) - 16'h0001))
      else $error("count did not decrement");

   a_tc_mask: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      (tc_evt[1] && !mode_q[1][cid_pkg::MODE_AUTO] && !mclr[0])
      |=> ##[0:2] (mask_q[0][1] && tc_q[0][1]))
      else $error("terminal count did not mask channel");

   a_tc_clear: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      (stat_rd[0] && tc_evt[3:0] == 4'h0) |=> (tc_q[0] == 4'h0))
      else $error("status read left terminal count set");

endmodule : cid_top

/* File: bench/cid_periph.sv */
// peripheral side model: one dma request line per channel
// assumes dack is one-hot, registered, and raised for whole grants
`timescale 1ns/1ps
module cid_periph (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic slow_in,
   input wire logic [7:0] want_in,
   input wire logic [7:0] dack_in,
   output logic [7:0] dreq_out
);
   logic [7:0] rest_q;

   // ==========================================================
   // request held until acknowledged; a slow device rests a cycle more
   always_ff @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         dreq_out <= 8'h00;
         rest_q <= 8'h00;
      end
      else
      begin
         rest_q <= dack_in & {8{slow_in}};
         dreq_out <= want_in & ~dack_in & ~rest_q;
      end
   end
endmodule : cid_periph

/* File: bench/test_cascaded_isa_dma_controller.sv */
// self-checking bench for the cascaded dma block
// assumes the peripheral model cid_periph and one 20 MHz clock
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
   begin \
      total_checks++; \
      if ((gt) !== (ex)) \
      begin \
         n_fail++; \
         $display("MISMATCH %s exp %h got %h", nm, ex, gt); \
      end \
   end
module test_cascaded_isa_dma_controller;
   logic ref_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cpu_reset_output_in = 1'b0;
   logic slow = 1'b0;
   cid_pkg::cid_io_t io_req = '0;
   logic [7:0] io_rdata;
   logic [7:0] dreq;
   logic [7:0] dack;
   logic [23:0] sys_addr;
   cid_pkg::cid_xfer_t xfer;
   logic [7:0] want = 8'h00;
   int n_fail = 0;
   int total_checks = 0;

   always #25 ref_clk_in = ~ref_clk_in;

   cid_top dut_u (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .cpu_reset_output_in(cpu_reset_output_in),
      .io_req_in(io_req),
      .io_rdata_out(io_rdata),
      .dreq_in(dreq),
      .dack_out(dack),
      .sys_addr_out(sys_addr),
      .xfer_out(xfer)
   );

   cid_periph periph_u (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .slow_in(slow),
      .want_in(want),
      .dack_in(dack),
      .dreq_out(dreq)
   );

   // ==========================================================
   // shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : tick

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      io_req = '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
      tick(1);
      io_req = '0;
      tick(1);
   endtask : io_wr

   task automatic io_chk(input logic [7:0] a, input logic [7:0] e,
                         input string nm);
      io_req = '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
      tick(1);
      io_req = '0;
      `CHK(nm, e, io_rdata)
      tick(1);
   endtask : io_chk

   task automatic w16(input logic [7:0] a, input logic [15:0] v);
      io_wr(a, v[7:0]);
      io_wr(a, v[15:8]);
   endtask : w16

   task automatic c16(input logic [7:0] a, input logic [15:0] v,
                      input string nm);
      io_chk(a, v[7:0], nm);
      io_chk(a, v[15:8], nm);
   endtask : c16

   // etwk holds the expected {tc, wide, kind} of the transfer strobe
   task automatic grant(input int ch, input logic [23:0] ea,
                        input logic [3:0] etwk);
      int i;
      i = 0;
      while (dack === 8'h00 && i < 40)
      begin
         tick(1);
         i++;
      end
      if (dack === 8'h00)
      begin
         n_fail++;
         $display("MISMATCH grant wait exp %0d got %h", ch, dack);
         test_done();
      end
      else
      begin
         `CHK("dack", 8'(8'h01 << ch), dack)
         `CHK("sys_addr", ea, sys_addr)
         tick(1);
         `CHK("xfer", {1'b1, etwk}, xfer)
         tick(2);
      end
   endtask : grant

   task automatic quiet(input int n);
      repeat (n)
      begin
         tick(1);
         `CHK("idle dack", 8'h00, dack)
      end
   endtask : quiet

   // ==========================================================
   // scenarios
   task automatic t_reset;
      io_chk(8'h08, 8'h00, "status");
      io_chk(8'h87, 8'h00, "page");
      io_chk(8'h40, 8'h00, "unmapped");
      c16(8'h00, 16'h0000, "ch0 addr");
      want = 8'h01;
      quiet(6);
      want = 8'h00;
   endtask : t_reset

   task automatic t_regs;
      w16(8'h00, 16'h1234);
      c16(8'h00, 16'h1234, "ch0 addr");
      w16(8'hc3, 16'hbeef);
      c16(8'hc3, 16'hbeef, "ch5 count");
      io_wr(8'h8b, 8'h5a);
      io_chk(8'h8b, 8'h5a, "page 8b");
      io_wr(8'h00, 8'h77);
      io_chk(8'h00, 8'h12, "ptr high");
      io_wr(8'h0c, 8'h01);
      io_chk(8'h00, 8'h12, "ptr set");
      io_wr(8'h0c, 8'h01);
      cpu_reset_output_in = 1'b1;
      tick(1);
      cpu_reset_output_in = 1'b0;
      io_chk(8'h00, 8'h77, "cpu reset ptr");
      io_wr(8'h0d, 8'h00);
      io_chk(8'h00, 8'h77, "clear ptr");
      io_wr(8'h0c, 8'h00);
   endtask : t_regs

   task automatic t_byte;
      io_wr(8'h0a, 8'h05);
      w16(8'h02, 16'h0100);
      w16(8'h03, 16'h0001);
      io_wr(8'h83, 8'h05);
      io_wr(8'h0b, 8'h09);
      io_wr(8'hce, 8'h00);
      io_wr(8'h0a, 8'h01);
      want = 8'h02;
      grant(1, 24'h050100, 4'b0010);
      grant(1, 24'h050101, 4'b1010);
      quiet(10);
      io_chk(8'h08, 8'h22, "status tc");
      io_chk(8'h08, 8'h20, "status reread");
      want = 8'h00;
      c16(8'h02, 16'h0102, "ch1 addr");
      c16(8'h03, 16'hffff, "ch1 count");
   endtask : t_byte

   task automatic t_word;
      slow = 1'b1;
      w16(8'hc2, 16'h2000);
      w16(8'hc3, 16'h0001);
      io_wr(8'h8b, 8'h06);
      io_wr(8'hcb, 8'h31);
      io_wr(8'hca, 8'h01);
      want = 8'h30;
      grant(5, 24'h064000, 4'b0100);
      grant(5, 24'h063ffe, 4'b1100);
      grant(5, 24'h064000, 4'b0100);
      io_wr(8'hca, 8'h05);
      want = 8'h10;
      quiet(8);
      io_chk(8'hc8, 8'h02, "word status");
      c16(8'hc2, 16'h1fff, "ch5 addr");
      want = 8'h00;
      slow = 1'b0;
   endtask : t_word

   task automatic t_hold;
      io_wr(8'h0d, 8'h00);
      io_wr(8'h08, 8'h02);
      w16(8'h00, 16'h0300);
      w16(8'h01, 16'h0001);
      io_wr(8'h0a, 8'h00);
      want = 8'h01;
      // back-to-back status reads keep the byte controller programming
      io_req = '{rd: 1'b1, wr: 1'b0, addr: 8'h08, data: 8'h00};
      repeat (3)
      begin
         tick(1);
         `CHK("prog dack", 8'h00, dack)
      end
      io_req = '0;
      grant(0, 24'h000300, 4'b0000);
      grant(0, 24'h000300, 4'b1000);
      want = 8'h00;
      quiet(6);
      io_wr(8'h08, 8'h04);
      io_wr(8'h0f, 8'h00);
      want = 8'h01;
      quiet(6);
      want = 8'h00;
   endtask : t_hold

   // ==========================================================
   // main sequence
   initial
   begin
      tick(4);
      rstn_in = 1'b1;
      tick(1);
      t_reset();
      t_regs();
      t_byte();
      t_word();
      t_hold();
      test_done();
   end
endmodule : test_cascaded_isa_dma_controller
